// ==== design/sad_decoder.sv ====
// address decoder, strobes and bus glue for the processor backplane
// assumes processor address and cycle qualifiers come from logic on clk;
// pins from other boards and the oscillator are synchronised here
`timescale 1ns/1ps
`default_nettype none

module sad_decoder
    import sad_pkg::*;
#(
    parameter int STABLE_CYC = sad_pkg::STABLE_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      osc_4mhz,
    input  wire logic [15:0]               cpu_addr,
    input  wire logic                      cpu_cycle,
    input  wire logic                      cpu_read,
    input  wire logic [7:0]                cpu_wdata,
    input  wire logic                      coproc_hold_off,
    input  wire logic                      ram_supply_good,
    input  wire logic                      gpib_service_n,
    input  wire logic                      key_press_interrupt_n,
    input  wire logic [sad_pkg::SW_WIDTH-1:0] addr_switch,
    output logic                           sys_clk_2mhz,
    output logic                           power_up_reset,
    output logic                           rd_strobe_n,
    output logic                           wr_strobe_n,
    output logic                           offboard_mem_request_n,
    output logic                           io_cycle_request_n,
    output logic [1:0]                     onboard_ram_sel_n,
    output logic                           battery_backed_ram_sel_n,
    output logic [1:0]                     volatile_ram_sel_n,
    output logic                           noise_calibration_table_sel_n,
    output logic                           exp_ram_write_en,
    output logic                           ram_power_ready,
    output logic [sad_pkg::ROM_COUNT-1:0]  prog_rom_sel_n,
    output logic [sad_pkg::GPIB_WINS-1:0]  gpib_win_sel_n,
    output logic                           cpu_stretch,
    output logic                           cpu_nmi_n,
    output logic                           cpu_irq_n,
    output logic [7:0]                     cpu_rdata,
    output logic                           cpu_rdata_oe,
    output logic                           controller_drive_en
);

    // ==========================================================
    // synchronisers for every pin from outside this clock
    logic                osc_s;      // oscillator level
    logic                hold_s;     // coprocessor hold-off, low = busy
    logic                supply_s;   // RAM supply good
    logic                nmi_s;      // service request, low active
    logic                key_s;      // key interrupt, low active
    logic [SW_WIDTH-1:0] sw_s;       // fallback address switches

    // idle levels at reset so nothing fires spuriously;
    // msb first: oscillator low, hold-off idle high, supply not
    // yet good, both interrupt pins at their idle high level
    sad_sync2 #(.W(5), .RESET_VAL(5'h0B)) u_sync_ctl (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({osc_4mhz, coproc_hold_off, ram_supply_good,
                    gpib_service_n, key_press_interrupt_n}),
        .sync_out ({osc_s, hold_s, supply_s, nmi_s, key_s})  // R9
    );

    sad_sync2 #(.W(SW_WIDTH), .RESET_VAL(5'h00)) u_sync_sw (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (addr_switch),
        .sync_out (sw_s)
    );

    // ==========================================================
    // power-up reset and 2 MHz backplane clock
    sad_por_clkdiv #(.STABLE_CYC(STABLE_CYC)) u_por (
        .clk            (clk),
        .reset_n        (reset_n),
        .osc_sync       (osc_s),
        .power_up_reset (power_up_reset),
        .sys_clk_2mhz   (sys_clk_2mhz)
    );

    // ==========================================================
    // address decode, all combinational from the cycle qualifiers
    logic run;        // system out of reset
    logic cyc;        // a qualified bus cycle is live
    logic hit_ram0;   // first on-board 2K
    logic hit_ram1;   // second on-board 2K
    logic hit_io;     // 256-byte I/O window
    logic hit_off;    // anything else goes off-board
    logic hit_exp;    // 8K expansion board region
    logic hit_rom;    // program ROM region
    logic ram_ready;  // expansion RAM may be used
    logic [2:0] rom_blk;  // 8K block number

    assign run      = reset_n && !power_up_reset;
    assign cyc      = cpu_cycle && run;  // R21
    assign hit_ram0 = win_hit(cpu_addr, ONB_RAM0_BASE, BLK_2K_SHIFT);  // R1
    assign hit_ram1 = win_hit(cpu_addr, ONB_RAM1_BASE, BLK_2K_SHIFT);  // R1
    assign hit_io   = win_hit(cpu_addr, IO_BASE, IO_SHIFT);  // R2
    // priority order makes the three classes disjoint
    assign hit_off  = !hit_ram0 && !hit_ram1 && !hit_io;  // R3 R21
    assign hit_exp  = win_hit(cpu_addr, EXP_BASE, EXP_SHIFT);
    assign rom_blk  = cpu_addr[15:13];
    assign hit_rom  = rom_blk >= ROM_FIRST_BLK;  // R14

    // ready only once the supply is good and reset is over
    assign ram_ready       = supply_s && run;  // R7
    assign ram_power_ready = ram_ready;  // R7

    // ==========================================================
    // backplane strobes, all active low
    always_comb begin
        rd_strobe_n            = !(cyc && cpu_read);  // R16
        wr_strobe_n            = !(cyc && !cpu_read);  // R16
        io_cycle_request_n     = !(cyc && hit_io);  // R2 R16
        offboard_mem_request_n = !(cyc && hit_off);  // R3 R20
    end

    // ==========================================================
    // on-board RAM selects, never with an off-board request
    always_comb begin
        onboard_ram_sel_n[0] = !(cyc && hit_ram0);  // R1
        onboard_ram_sel_n[1] = !(cyc && hit_ram1);  // R1
    end

    // ==========================================================
    // expansion RAM board; these live inside the off-board space
    logic exp_cyc;   // off-board cycle in the expansion region
    assign exp_cyc = cyc && hit_off && hit_exp;

    always_comb begin
        battery_backed_ram_sel_n = !(exp_cyc &&
            win_hit(cpu_addr, BATT_BASE, BLK_2K_SHIFT));  // R4
        volatile_ram_sel_n[0]    = !(exp_cyc &&
            win_hit(cpu_addr, VOL0_BASE, BLK_2K_SHIFT));  // R5
        volatile_ram_sel_n[1]    = !(exp_cyc &&
            win_hit(cpu_addr, VOL1_BASE, BLK_2K_SHIFT));  // R5
        // the socket may be empty; decode regardless
        noise_calibration_table_sel_n = !(exp_cyc &&
            win_hit(cpu_addr, CAL_ROM_BASE, BLK_2K_SHIFT));  // R6
        // writes blocked while supply is still coming up
        exp_ram_write_en = exp_cyc && !cpu_read && ram_ready;  // R7
    end

    // ==========================================================
    // program ROM bank: one of six, read cycles only
    genvar gi;
    generate
        for (gi = 0; gi < ROM_COUNT; gi++) begin : g_rom
            always_comb begin
                prog_rom_sel_n[gi] = !(cyc && cpu_read && hit_off &&
                    hit_rom &&
                    (rom_blk == 3'(gi + ROM_FIRST_BLK)));  // R14 R15
            end
        end
    endgenerate

    // ==========================================================
    // instrument-bus board windows inside the I/O request space
    logic [15:0] gpib_base [GPIB_WINS];   // window bases
    assign gpib_base[0] = GPIB0_BASE;
    assign gpib_base[1] = GPIB1_BASE;
    assign gpib_base[2] = GPIB2_BASE;

    generate
        for (gi = 0; gi < GPIB_WINS; gi++) begin : g_gpib
            always_comb begin
                gpib_win_sel_n[gi] = !(cyc && hit_io &&
                    win_hit(cpu_addr, gpib_base[gi], GPIB_SHIFT));  // R19
            end
        end
    endgenerate

    // ==========================================================
    // cycle stretch: coprocessor busy, or RAM not yet powered;
    // costs two clocks of latency on release, far below a bus cycle
    always_comb begin
        cpu_stretch = cyc && (!hold_s ||
                      (hit_off && hit_exp && !ram_ready));  // R8 R7
    end

    // ==========================================================
    // interrupts straight through after synchronising
    assign cpu_nmi_n = nmi_s;  // R12
    assign cpu_irq_n = key_s;  // R13

    // ==========================================================
    // switch read-back and controller latch
    logic sw_rd;   // read of the switch buffer
    logic ctl_wr;  // write of the controller latch
    assign sw_rd  = cyc && cpu_read && hit_io && (cpu_addr == SWITCH_ADDR);
    assign ctl_wr = cyc && !cpu_read && hit_io && (cpu_addr == CTL_ADDR);

    // rightmost switch is the least significant bit
    function automatic logic [SW_WIDTH-1:0] sw_flip(
        input logic [SW_WIDTH-1:0] v);
        logic [SW_WIDTH-1:0] r;
        r = '0;
        for (int i = 0; i < SW_WIDTH; i++) begin
            r[i] = v[SW_WIDTH-1-i];
        end
        return r;
    endfunction : sw_flip

    sad_state_type s_q, s_d;

    // next state of buffer and latch
    always_comb begin
        s_d          = s_q;
        s_d.rdata_oe = sw_rd;
        if (sw_rd) begin
            s_d.rdata = {3'h0, sw_flip(sw_s)};  // R17
        end else begin
            s_d.rdata = 8'h00;
        end
        if (ctl_wr) begin
            s_d.ctl_drive = cpu_wdata[CTL_DRIVE_BIT];  // R18
        end
    end

    // register the state; system reset clears the latch
    always_ff @(posedge clk) begin
        if (!reset_n || power_up_reset) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_rdata           = s_q.rdata;
    assign cpu_rdata_oe        = s_q.rdata_oe;
    assign controller_drive_en = s_q.ctl_drive;  // R18

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // lets $past look back across the synchronisers after reset
    logic [1:0] up_cnt;  // cycles since reset release, saturating
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end

    onb_ram_map_a: assert property (  // R1
        (cpu_cycle && run && cpu_addr < 16'h1000)
        |-> (offboard_mem_request_n &&
             onboard_ram_sel_n == {!cpu_addr[11], cpu_addr[11]}))
        else $error("on-board RAM select wrong");

    io_window_a: assert property (  // R2
        !io_cycle_request_n == (cpu_cycle && run &&
                                cpu_addr[15:8] == 8'h1F))
        else $error("I/O request window wrong");

    offboard_req_a: assert property (  // R3
        (cpu_cycle && run && cpu_addr >= 16'h1000 &&
         cpu_addr[15:8] != 8'h1F) |-> !offboard_mem_request_n)
        else $error("off-board request missing");

    exp_map_a: assert property (  // R4
        !battery_backed_ram_sel_n |->
        (cpu_addr[15:11] == 5'h04 && !offboard_mem_request_n))
        else $error("battery-backed RAM map wrong");

    vol_map_a: assert property (  // R5
        (!volatile_ram_sel_n[0] |-> cpu_addr[15:11] == 5'h05) and
        (!volatile_ram_sel_n[1] |-> cpu_addr[15:11] == 5'h06))
        else $error("volatile RAM map wrong");

    cal_rom_map_a: assert property (  // R6
        (cpu_cycle && run && cpu_addr[15:11] == 5'h07)
        |-> !noise_calibration_table_sel_n)
        else $error("calibration ROM not selected");

    ram_ready_gate_a: assert property (  // R7
        (up_cnt == 2'h3 && !$past(ram_supply_good, 2))
        |-> (!ram_power_ready && !exp_ram_write_en))
        else $error("RAM used before supply good");

    hold_stretch_a: assert property (  // R8
        (up_cnt == 2'h3 && cpu_cycle && run &&
         $past(coproc_hold_off, 2) == 1'b0) |-> cpu_stretch)
        else $error("cycle not stretched while busy");

    hold_sync_a: assert property (  // R9
        (up_cnt == 2'h3 && cpu_cycle && run && cpu_addr < 16'h2000 &&
         $past(coproc_hold_off, 2)) |-> !cpu_stretch)
        else $error("stretch without synced hold-off");

    rom_bank_a: assert property (  // R14
        $onehot0(~prog_rom_sel_n))
        else $error("more than one ROM selected");

    rom_enable_a: assert property (  // R15
        (prog_rom_sel_n != 6'h3F) |->
        (!rd_strobe_n && !offboard_mem_request_n &&
         !prog_rom_sel_n[cpu_addr[15:13] - 3'h2]))
        else $error("ROM enabled without read and request");

    irq_path_a: assert property (  // R12
        up_cnt == 2'h3 |-> (cpu_nmi_n == $past(gpib_service_n, 2) &&
                            cpu_irq_n == $past(key_press_interrupt_n, 2)))
        else $error("interrupt path wrong");

    strobe_pair_a: assert property (  // R16
        !(rd_strobe_n == 1'b0 && wr_strobe_n == 1'b0))
        else $error("read and write strobes together");

    switch_read_a: assert property (  // R17
        (cpu_cycle && run && cpu_read && cpu_addr == SWITCH_ADDR &&
         up_cnt == 2'h3) |=>
        (cpu_rdata_oe && cpu_rdata[0] == $past(addr_switch[4], 3)))
        else $error("switch read-back wrong");

    ctl_latch_a: assert property (  // R18
        (cpu_cycle && run && !cpu_read && cpu_addr == CTL_ADDR)
        |=> controller_drive_en == $past(cpu_wdata[0]))
        else $error("controller latch not written");

    gpib_win_a: assert property (  // R19
        !gpib_win_sel_n[1] |-> (cpu_addr[15:3] == 13'h03FD &&
                                !io_cycle_request_n))
        else $error("instrument-bus window wrong");

    one_select_a: assert property (  // R20 R21
        $onehot0({!offboard_mem_request_n, !io_cycle_request_n,
                  ~onboard_ram_sel_n}) and
        (power_up_reset |-> offboard_mem_request_n))
        else $error("more than one select active");

    cover_rom_read_c:  cover property (!prog_rom_sel_n[5]);
    cover_stretch_c:   cover property (cpu_stretch [*3] ##1 !cpu_stretch);
    cover_ctl_set_c:   cover property (controller_drive_en);
    cover_exp_write_c: cover property (exp_ram_write_en);

endmodule : sad_decoder

`default_nettype wire

// ==== design/sad_pkg.sv ====
// constants, decode helper and state type for the system address decoder
// assumes a 16-bit processor address bus and one 200 MHz clock
//
// How it works
// R1: lowest two 2K blocks pick on-board RAMs
// R2: window 1F00-1FFF becomes an I/O request
// R3: everything else raises the off-board memory request
// R4: battery-backed RAM answers at 2000-27FF
// R5: volatile RAMs answer at 2800 and 3000
// R6: optional calibration ROM answers at 3800-3FFF
// R7: RAM writes wait for supply good; ready flag
// R8: low hold-off from coprocessor stretches the cycle
// R9: hold-off passes a two-flop synchroniser first
// R10: 4 MHz source halved into 2 MHz clock
// R11: power-up reset holds until oscillator settles
// R12: bus-board service request drives the NMI
// R13: key press interrupt drives the maskable IRQ
// R14: upper address bits pick one of six ROMs
// R15: ROMs enabled only on read with memory request
// R16: separate read, write and I/O request strobes
// R17: five-bit switch readable, rightmost switch LSB
// R18: latched bit enables REN and ATN drivers
// R19: separate selects for 1FE0, 1FE8 and 1FF0
// R20: memory request is active low
// R21: one select per cycle, none in reset

package sad_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ        = 200;  // system clock rate
    localparam int STABLE_TIME_US = 50;   // oscillator settling
    localparam int STABLE_CYCLES  = STABLE_TIME_US * CLK_MHZ;

    // ==========================================================
    // memory map: base and log2 of window size
    localparam logic [15:0] ONB_RAM0_BASE = 16'h0000;
    localparam logic [15:0] ONB_RAM1_BASE = 16'h0800;
    localparam int          BLK_2K_SHIFT  = 11;
    localparam logic [15:0] IO_BASE       = 16'h1F00;
    localparam int          IO_SHIFT      = 8;
    localparam logic [15:0] BATT_BASE     = 16'h2000;
    localparam logic [15:0] VOL0_BASE     = 16'h2800;
    localparam logic [15:0] VOL1_BASE     = 16'h3000;
    localparam logic [15:0] CAL_ROM_BASE  = 16'h3800;
    localparam logic [15:0] EXP_BASE      = 16'h2000;
    localparam int          EXP_SHIFT     = 13;
    localparam int          ROM_SHIFT     = 13;
    localparam int          ROM_COUNT     = 6;
    localparam logic [2:0]  ROM_FIRST_BLK = 3'h2;
    localparam logic [15:0] GPIB0_BASE    = 16'h1FE0;
    localparam logic [15:0] GPIB1_BASE    = 16'h1FE8;
    localparam logic [15:0] GPIB2_BASE    = 16'h1FF0;
    localparam int          GPIB_SHIFT    = 3;
    localparam int          GPIB_WINS     = 3;
    localparam logic [15:0] SWITCH_ADDR   = 16'h1FF8;
    localparam logic [15:0] CTL_ADDR      = 16'h1FF9;
    localparam int          CTL_DRIVE_BIT = 0;
    localparam int          SW_WIDTH      = 5;

    // ==========================================================
    // registered state of the decoder top
    typedef struct packed {
        logic       ctl_drive;  // controller driver enable latch
        logic [7:0] rdata;      // read-back data buffer
        logic       rdata_oe;   // buffer drives the data bus
    } sad_state_type;

    localparam sad_state_type STATE_RESET = '{1'b0, 8'h00, 1'b0};

    // address falls in an aligned window of 2**sh bytes
    function automatic logic win_hit(input logic [15:0] a,
                                     input logic [15:0] base,
                                     input int          sh);
        return (a >> sh) == (base >> sh);
    endfunction : win_hit

endpackage : sad_pkg

// ==== design/sad_sync2.sv ====
// two-flop synchroniser for pin-level inputs
// assumes inputs are asynchronous levels; reset value is a constant
`timescale 1ns/1ps
`default_nettype none

module sad_sync2 #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // ==========================================================
    // flop chain; first stage read by the second only
    logic [W-1:0] meta_q;   // metastability catcher
    logic [W-1:0] sync_q;   // settled copy

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : sad_sync2

`default_nettype wire

// ==== design/sad_por_clkdiv.sv ====
// power-up reset timer and divide-by-two of the 4 MHz source
// assumes the oscillator level arrives already synchronised
`timescale 1ns/1ps
`default_nettype none

module sad_por_clkdiv
    import sad_pkg::*;
#(
    parameter int STABLE_CYC = sad_pkg::STABLE_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic osc_sync,
    output logic      power_up_reset,
    output logic      sys_clk_2mhz
);

    typedef enum logic [1:0] {
        POR_HOLD = 2'b00,   // oscillator settling
        POR_RUN  = 2'b01    // reset released
    } sad_por_type;

    typedef struct packed {
        sad_por_type st;
        logic [31:0] cnt;    // settling counter
        logic        osc_d;  // last oscillator level
        logic        clk2;   // divided clock
    } sad_por_state_type;

    sad_por_state_type s_q, s_d;

    // ==========================================================
    // next state
    always_comb begin
        s_d       = s_q;
        s_d.osc_d = osc_sync;
        // toggle on each source rising edge halves it
        if (osc_sync && !s_q.osc_d) begin
            s_d.clk2 = !s_q.clk2;  // R10
        end
        case (s_q.st)
            POR_HOLD: begin
                // hold until the settling time has passed
                if (s_q.cnt >= 32'(STABLE_CYC - 1)) begin
                    s_d.st = POR_RUN;  // R11
                end else begin
                    s_d.cnt = s_q.cnt + 32'h1;
                end
            end
            POR_RUN:  s_d.st = POR_RUN;
            default:  s_d.st = POR_HOLD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '{POR_HOLD, 32'h0, 1'b0, 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign power_up_reset = (s_q.st != POR_RUN);  // R11
    assign sys_clk_2mhz   = s_q.clk2;

endmodule : sad_por_clkdiv

`default_nettype wire

// ==== dv/sad_far_model.sv ====
// far side: 4 MHz oscillator and math coprocessor hold-off
// assumes the bench pulses busy_go for one clk with busy_len set
`timescale 1ns/1ps
`default_nettype none

module sad_far_model (
    input  wire logic       clk,
    input  wire logic       busy_go,
    input  wire logic [7:0] busy_len,
    output logic            osc_4mhz,
    output logic            coproc_hold_off
);
    logic [7:0] left_q = 8'h00; // busy cycles still to run

    // ==========
    // free-running source, 250 ns period
    initial begin
        osc_4mhz = 1'h0;
        forever #125 osc_4mhz = ~osc_4mhz;
    end

    // held low while calculating, high once the result is valid
    always_ff @(posedge clk) begin
        if (busy_go) begin
            left_q <= busy_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign coproc_hold_off = (left_q == 8'h00);
endmodule : sad_far_model
`default_nettype wire

// ==== dv/system_address_decoder_tb.sv ====
// self-checking bench for the address decoder
// assumes STABLE_CYC of 8 and a far-side model for oscillator and hold-off
`timescale 1ns/1ps
`default_nettype none

module system_address_decoder_tb;
    logic        clk = 1'h0, reset_n = 1'h0, cpu_cycle = 1'h1, cpu_read = 1'h1;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00, busy_len = 8'h00, cpu_rdata;
    logic        busy_go = 1'h0, ram_supply_good = 1'h1, gpib_service_n = 1'h1;
    logic        key_press_interrupt_n = 1'h1, osc_4mhz, coproc_hold_off;
    logic [4:0]  addr_switch = 5'h00;
    logic        sys_clk_2mhz, power_up_reset, rd_strobe_n, wr_strobe_n;
    logic        offboard_mem_request_n, io_cycle_request_n, battery_backed_ram_sel_n;
    logic        noise_calibration_table_sel_n, exp_ram_write_en, ram_power_ready;
    logic        cpu_stretch, cpu_nmi_n, cpu_irq_n, cpu_rdata_oe, controller_drive_en;
    logic [1:0]  onboard_ram_sel_n, volatile_ram_sel_n;
    logic [5:0]  prog_rom_sel_n;
    logic [2:0]  gpib_win_sel_n;
    logic [19:0] sel_vec; // every select and strobe, inactive = 7FFFF
    int          bad_count = 0, compares = 0, toggles = 0;
    localparam logic [15:0] ADDRS [22] = '{16'h0000, 16'h07FF, 16'h0800, 16'h0FFF,
        16'h1000, 16'h1EFF, 16'h1F00, 16'h1FE0, 16'h1FE8, 16'h1FF7, 16'h1FFF, 16'h2000,
        16'h27FF, 16'h2800, 16'h3000, 16'h37FF, 16'h3800, 16'h3FFF, 16'h4000, 16'h7FFF,
        16'hA000, 16'hFFFF};

    assign sel_vec = {exp_ram_write_en, offboard_mem_request_n, io_cycle_request_n,
        onboard_ram_sel_n, battery_backed_ram_sel_n, volatile_ram_sel_n,
        noise_calibration_table_sel_n, prog_rom_sel_n, gpib_win_sel_n, rd_strobe_n,
        wr_strobe_n};

    sad_decoder #(.STABLE_CYC(8)) u_sad_decoder (.*);
    sad_far_model u_sad_far_model (.*);

    // ==========
    // clock, edge counter and watchdog
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(sys_clk_2mhz) toggles++;
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end

    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // expected selects from the memory map, active low, write enable high
    function automatic logic [19:0] exp_vec(input logic [15:0] a, input logic rd);
        logic [19:0] v;
        v = 20'h7FFFF;
        v[19] = !rd && a[15:13] == 3'h1;
        v[18] = (a < 16'h1000) || a[15:8] == 8'h1F;
        v[17] = a[15:8] != 8'h1F;
        case (a[15:11])
            5'h00: v[15] = 1'h0;
            5'h01: v[16] = 1'h0;
            5'h04: v[14] = 1'h0;
            5'h05: v[12] = 1'h0;
            5'h06: v[13] = 1'h0;
            5'h07: v[11] = 1'h0;
            default: ;
        endcase
        if (rd && a[15:13] >= 3'h2) v[a[15:13] + 3] = 1'h0;
        if (a[15:5] == 11'h0FF && a[4:3] != 2'h3) v[a[4:3] + 2] = 1'h0;
        v[1] = !rd;
        v[0] = rd;
        return v;
    endfunction : exp_vec

    // 22 map addresses, read and write, then an idle bus
    task automatic t_decode();
        foreach (ADDRS[k]) begin
            for (int r = 0; r < 2; r++) begin
                cpu_addr = ADDRS[k];
                cpu_read = r[0];
                #1 chk("map", sel_vec, exp_vec(ADDRS[k], r[0]));
                chk("stretch", {19'h0, cpu_stretch}, 20'h0);
                @(negedge clk);
            end
        end
        cpu_cycle = 1'h0;
        #1 chk("idle", sel_vec, 20'h7FFFF);
    endtask : t_decode

    // expansion write refused until supply is good
    task automatic t_ready();
        ram_supply_good = 1'h0;
        cpu_addr = 16'h2800;
        cpu_read = 1'h0;
        cpu_cycle = 1'h1;
        repeat (4) @(negedge clk);
        chk("not ready", {ram_power_ready, exp_ram_write_en, cpu_stretch}, 20'h1);
        ram_supply_good = 1'h1;
        repeat (4) @(negedge clk);
        chk("ready", {ram_power_ready, exp_ram_write_en, cpu_stretch}, 20'h6);
    endtask : t_ready

    // six busy cycles stretch exactly six cycles, after synchronising
    task automatic t_hold();
        int n = 0;
        cpu_addr = 16'h1000;
        busy_len = 8'h06;
        busy_go = 1'h1;
        @(negedge clk);
        busy_go = 1'h0;
        chk("early stretch", {19'h0, cpu_stretch}, 20'h0);
        repeat (12) begin
            @(negedge clk);
            n += cpu_stretch;
        end
        chk("stretch cycles", n[19:0], 20'h6);
    endtask : t_hold

    // each interrupt pin reaches only its own output
    task automatic t_irq();
        for (int i = 0; i < 2; i++) begin
            gpib_service_n = i[0];
            key_press_interrupt_n = !i[0];
            @(negedge clk);
            chk("irq sync", {18'h0, cpu_nmi_n, cpu_irq_n}, i ? 20'h1 : 20'h3);
            repeat (2) @(negedge clk);
            chk("irq", {18'h0, cpu_nmi_n, cpu_irq_n}, i ? 20'h2 : 20'h1);
        end
        key_press_interrupt_n = 1'h1;
    endtask : t_irq

    // switch read reversed, then the controller latch set and cleared
    task automatic t_switch();
        addr_switch = 5'h16;
        cpu_addr = 16'h1FF8;
        cpu_read = 1'h1;
        repeat (3) @(negedge clk);
        cpu_cycle = 1'h0;
        chk("switch", {11'h0, cpu_rdata_oe, cpu_rdata}, 20'h10D);
        @(negedge clk);
        chk("switch oe", {19'h0, cpu_rdata_oe}, 20'h0);
        for (int v = 1; v >= 0; v--) begin
            cpu_addr = 16'h1FF9;
            cpu_read = 1'h0;
            cpu_wdata = v[7:0];
            cpu_cycle = 1'h1;
            @(negedge clk);
            chk("driver en", {19'h0, controller_drive_en}, v[19:0]);
        end
    endtask : t_switch

    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // ==========
    // reset and power-up hold, then each scenario
    initial begin
        int n;
        repeat (20) @(negedge clk);
        chk("in reset", {power_up_reset, sel_vec[18:0]}, 20'hFFFFF);
        chk("reset outs", {16'h0, cpu_nmi_n, cpu_irq_n, ram_power_ready, cpu_stretch}, 20'hC);
        reset_n = 1'h1;
        repeat (6) @(negedge clk);
        chk("power-up", {power_up_reset, sel_vec[18:0]}, 20'hFFFFF);
        repeat (8) @(negedge clk);
        chk("run", {19'h0, power_up_reset}, 20'h0);
        t_decode();
        t_ready();
        t_hold();
        t_irq();
        t_switch();
        @(posedge osc_4mhz);
        #60 n = toggles;
        #2500 chk("divide", 20'(toggles - n), 20'hA);
        tally_and_finish();
    end
endmodule : system_address_decoder_tb
`default_nettype wire
